// ===== core/serial_status_and_port_control.sv
// Serial interface core: status flags, shifters, clock select and port pin control
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Internal clock with clock output in async mode drives bit-rate clock on pin.
// - Status register resets to 0x84.
// - Error and receive-full flags clear only by zero write after reading one.
// - Transmit-end and received multiprocessor bits are read-only.
// - Transmit-empty sets on reset, transmitter off, or holding-to-shift move.
// - Transmit-empty clears by read-one-write-zero or holding register write.
// - Receive-full sets when an error-free character moves to holding register.
// - Overrun or receiver off leave holding data and receive-full unchanged.
// - New character while receive-full sets overrun and is discarded.
// - Error flags stop reception; in sync mode also block transmission.
// - Framing error when first stop bit is zero, second never checked.
// - Framing or parity error still copies data but leaves receive-full clear.
// - Parity error when ones count plus parity mismatches even or odd.
// - Receiver off keeps overrun, framing and parity flags.
// - Transmit-end sets on reset, transmitter off, or empty at last bit.
// - Transmit-end clears with the read-one-write-zero of transmit-empty.
// - Multiprocessor format captures received multiprocessor bit, kept when receiver off.
// - Bit 0 supplies the transmitted multiprocessor bit in async multiprocessor format.
// - Clock pin output select drives clock port value onto the pin unless external clock or async clock output is selected.
// - With clock pin output select off, clock pin level is readable through the clock port value bit.
// - Both clock enables zero in async uses internal clock, pin ignored.
// - Break select with transmitter off drives break value onto transmit pin.
// - With receiver on, receive pin level reads through break value bit.
module serial_status_and_port_control
   import serial_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic standby_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic txd_out,
   input wire logic rxd_in,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe_out
);
   // ****************************************
   // Bus decode
   // ****************************************
   apb_req_t req;
   logic clr_all, acc, wr, rd, hit;
   assign req = '{sel: psel_in, enable: penable_in, write: pwrite_in, addr: paddr_in,
                  wdata: pwdata_in};
   assign clr_all = rst_in | standby_in;
   assign acc = req.sel & req.enable;
   assign wr = acc & req.write;
   assign rd = acc & ~req.write;
   assign hit = (req.addr[1:0] == 2'b00) && (req.addr <= OFF_PORTDAT);
   assign pready_out = 1'b1;
   assign pslverr_out = acc & ~hit;

   logic [7:0] format_reg, rate_reg, control_reg, txhold_reg, rx_holding_reg;
   logic [7:0] status_reg, seen_reg;
   logic [31:0] rd_data_reg;
   logic [15:0] portctl_reg;
   logic clk_port_reg, brk_port_reg;
   logic wr_status, wr_txhold, rd_status;
   assign wr_status = wr && req.addr == OFF_STATUS;
   assign wr_txhold = wr && req.addr == OFF_TXDATA;
   assign rd_status = rd && req.addr == OFF_STATUS;

   // Plain configuration registers; all of them also clear with standby
   always_ff @(posedge clk_in) begin
      if (clr_all) begin
         format_reg <= 8'h00;
         rate_reg <= RATE_RESET;
         control_reg <= 8'h00;
         portctl_reg <= PORTCTL_RESET;
         clk_port_reg <= 1'b0;
         brk_port_reg <= 1'b0;
      end else if (wr) begin
         if (req.addr == OFF_FORMAT) format_reg <= req.wdata[7:0];
         if (req.addr == OFF_RATE) rate_reg <= req.wdata[7:0];
         if (req.addr == OFF_CONTROL) control_reg <= req.wdata[7:0];
         if (req.addr == OFF_PORTCTL) portctl_reg <= req.wdata[15:0];
         if (req.addr == OFF_PORTDAT) begin
            clk_port_reg <= req.wdata[PD_CLK];
            brk_port_reg <= req.wdata[PD_BRK];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (clr_all) txhold_reg <= 8'h00;
      else if (wr_txhold) txhold_reg <= req.wdata[7:0];
   end

   // ****************************************
   // Mode decode
   // ****************************************
   logic te, re, sync_mode, ext_clk, async_mp, use_par, err_any;
   assign te = control_reg[CT_TE];
   assign re = control_reg[CT_RE];
   assign sync_mode = format_reg[FM_SYNC];
   assign ext_clk = control_reg[CT_CLOCK_SOURCE_EXTERNAL];
   assign async_mp = ~sync_mode & format_reg[FM_MP];
   assign use_par = ~sync_mode & ~format_reg[FM_MP] & format_reg[FM_PE];
   assign err_any = status_reg[ST_OVR] | status_reg[ST_FRM] | status_reg[ST_PAR];

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic rxd_s1, rxd_s2, sck_s1, sck_s2, sck_d;
   always_ff @(posedge clk_in) begin
      rxd_s1 <= rxd_in;
      rxd_s2 <= rxd_s1;
      sck_s1 <= sck_in;
      sck_s2 <= sck_s1;
      sck_d <= sck_s2;
   end

   // ****************************************
   // Clock generation: oversample tick (16 per bit)
   // ****************************************
   // Internal divider gives one tick per (rate+1) cycles; external uses pin rise
   logic [7:0] div_reg;
   logic int_tick, ext_tick, os_tick;
   assign int_tick = (div_reg == rate_reg);
   assign ext_tick = sck_s2 & ~sck_d;
   // Pin edges count only with external clock selected
   assign os_tick = ext_clk ? ext_tick : int_tick;
   always_ff @(posedge clk_in) begin
      if (clr_all || int_tick) div_reg <= 8'h00;
      else div_reg <= div_reg + 8'h01;
   end

   // Free-running bit phase for the transmitter and the clock output
   logic [3:0] txph_reg;
   logic bit_tick;
   assign bit_tick = os_tick && txph_reg == OVERSAMPLE_LAST;
   always_ff @(posedge clk_in) begin
      if (clr_all) txph_reg <= 4'h0;
      else if (os_tick) txph_reg <= txph_reg + 4'h1;
   end

   // ****************************************
   // Transmitter
   // ****************************************
   tx_state_t tx_state;
   logic [8:0] tx_shift_reg;
   logic [3:0] tx_cnt_reg;
   logic [3:0] tx_len;
   logic tx_serial_reg, tx_load, tx_last, tx_block;
   assign tx_len = 4'h8 - {3'b000, format_reg[FM_CHR7]} + {3'b000, async_mp | use_par};
   // Sync mode transmission waits while any receive error stands
   assign tx_block = sync_mode & err_any;
   assign tx_load = bit_tick && tx_state == TX_IDLE && te && ~status_reg[ST_TX_HOLDING_EMPTY] && ~tx_block;
   assign tx_last = bit_tick && tx_state == TX_STOP &&
                    (tx_cnt_reg == {3'b000, format_reg[FM_STOP2]} || sync_mode);

   always_ff @(posedge clk_in) begin
      if (clr_all || !te) begin
         tx_state <= TX_IDLE;
         tx_serial_reg <= 1'b1;
         tx_shift_reg <= 9'h000;
         tx_cnt_reg <= 4'h0;
      end else if (bit_tick) begin
         case (tx_state)
            TX_IDLE: begin
               tx_serial_reg <= 1'b1;
               if (tx_load) begin
                  tx_shift_reg <= {1'b0, txhold_reg};
                  // Bit after the character: multiprocessor flag or computed parity
                  if (async_mp) tx_shift_reg[tx_len - 4'h1] <= status_reg[ST_TX_MULTIPROC_BIT];
                  else if (use_par) tx_shift_reg[tx_len - 4'h1] <=
                     ^(txhold_reg & (format_reg[FM_CHR7] ? 8'h7f : 8'hff)) ^ format_reg[FM_ODD];
                  tx_state <= sync_mode ? TX_BITS : TX_START;
                  tx_cnt_reg <= 4'h0;
               end
            end
            TX_START: begin
               tx_serial_reg <= 1'b0;
               tx_state <= TX_BITS;
            end
            TX_BITS: begin
               tx_serial_reg <= tx_shift_reg[0];
               tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
               tx_cnt_reg <= tx_cnt_reg + 4'h1;
               if (tx_cnt_reg == tx_len - 4'h1) begin
                  tx_state <= TX_STOP;
                  tx_cnt_reg <= 4'h0;
               end
            end
            TX_STOP: begin
               tx_serial_reg <= 1'b1;
               tx_cnt_reg <= tx_cnt_reg + 4'h1;
               if (tx_last) tx_state <= TX_IDLE;
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // ****************************************
   // Receiver (async, samples mid-bit)
   // ****************************************
   rx_state_t rx_state;
   logic [3:0] rxph_reg, rx_cnt_reg;
   logic [8:0] rx_shift_reg;
   logic rx_mid, rx_done, rx_frm, rx_par, rx_mpb;
   assign rx_mid = os_tick && rxph_reg == OVERSAMPLE_MID;
   always_ff @(posedge clk_in) begin
      if (clr_all || !re || err_any) begin
         rx_state <= RX_IDLE;
         rxph_reg <= 4'h0;
         rx_cnt_reg <= 4'h0;
         rx_shift_reg <= 9'h000;
      end else if (os_tick) begin
         rxph_reg <= rxph_reg + 4'h1;
         case (rx_state)
            RX_IDLE: if (!rxd_s2) begin
               rx_state <= RX_START;
               rxph_reg <= 4'h0;
            end
            RX_START: if (rx_mid) rx_state <= rxd_s2 ? RX_IDLE : RX_BITS;
            RX_BITS: if (rx_mid) begin
               rx_shift_reg <= {rxd_s2, rx_shift_reg[8:1]};
               rx_cnt_reg <= rx_cnt_reg + 4'h1;
               if (rx_cnt_reg == tx_len - 4'h1) rx_state <= RX_STOP;
            end
            RX_STOP: if (rx_mid) begin
               rx_state <= RX_IDLE;
               rx_cnt_reg <= 4'h0;
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   // Completed frame and its checks; second stop bit is treated as idle
   logic [8:0] rx_aligned;
   logic [7:0] rx_char;
   assign rx_done = rx_mid && rx_state == RX_STOP && re && ~err_any;
   assign rx_aligned = rx_shift_reg >> (4'h9 - tx_len);
   assign rx_char = format_reg[FM_CHR7] ? {1'b0, rx_aligned[6:0]} : rx_aligned[7:0];
   assign rx_frm = ~rxd_s2;
   assign rx_par = use_par && ((^rx_aligned[tx_len - 4'h1 -: 1] ^ ^rx_char) !=
                   format_reg[FM_ODD]);
   assign rx_mpb = rx_aligned[tx_len - 4'h1];

   // Holding register: overrun keeps old data; errors still copy data
   always_ff @(posedge clk_in) begin
      if (clr_all) rx_holding_reg <= 8'h00;
      else if (rx_done && !status_reg[ST_RX_HOLDING_FULL]) rx_holding_reg <= rx_char;
   end

   // ****************************************
   // Status flags
   // ****************************************
   // Remember flags read as one; a zero write clears only those
   always_ff @(posedge clk_in) begin
      if (clr_all) seen_reg <= 8'h00;
      else if (rd_status) seen_reg <= rd_data_reg[7:0];
      else if (wr_status) seen_reg <= 8'h00;
   end

   logic [7:0] sw_clr, hw_set, st_next;
   logic new_good;
   assign sw_clr = wr_status ? (seen_reg & ~req.wdata[7:0] & 8'hf8) : 8'h00;
   assign new_good = rx_done & ~status_reg[ST_RX_HOLDING_FULL] & ~rx_frm & ~rx_par;
   assign hw_set[ST_TX_HOLDING_EMPTY] = tx_load | ~te;
   assign hw_set[ST_RX_HOLDING_FULL] = new_good;
   assign hw_set[ST_OVR] = rx_done & status_reg[ST_RX_HOLDING_FULL];
   assign hw_set[ST_FRM] = rx_done & ~status_reg[ST_RX_HOLDING_FULL] & rx_frm;
   assign hw_set[ST_PAR] = rx_done & ~status_reg[ST_RX_HOLDING_FULL] & rx_par;
   assign hw_set[ST_TX_FINISHED] = ~te | (tx_last & status_reg[ST_TX_HOLDING_EMPTY]);
   assign hw_set[1:0] = 2'b00;

   // Set wins over clear; transmit-end follows the transmit-empty clear
   always_comb begin
      st_next = (status_reg & ~sw_clr) | hw_set;
      if (wr_txhold && !hw_set[ST_TX_HOLDING_EMPTY]) st_next[ST_TX_HOLDING_EMPTY] = 1'b0;
      if (sw_clr[ST_TX_HOLDING_EMPTY] && !hw_set[ST_TX_FINISHED]) st_next[ST_TX_FINISHED] = 1'b0;
      if (tx_load) st_next[ST_TX_FINISHED] = 1'b0;
      st_next[ST_MPB] = (rx_done && async_mp) ? rx_mpb : status_reg[ST_MPB];
      st_next[ST_TX_MULTIPROC_BIT] = wr_status ? req.wdata[ST_TX_MULTIPROC_BIT] : status_reg[ST_TX_MULTIPROC_BIT];
   end

   always_ff @(posedge clk_in) begin
      if (clr_all) status_reg <= STATUS_RESET;
      else status_reg <= st_next;
   end

   // ****************************************
   // Pins and port readback
   // ****************************************
   logic clk_drive, clk_level, brk_drive, pd_clk_rd, pd_brk_rd;
   // Clock output: bit-rate square wave from the bit phase
   assign clk_level = ~txph_reg[3];
   assign clk_drive = ~sync_mode & ~ext_clk & control_reg[CT_CLOCK_PIN_OUTPUT];
   assign brk_drive = portctl_reg[PC_BRK_OUT] & ~te;
   assign pd_clk_rd = portctl_reg[PC_CLK_OUT] ? clk_port_reg : sck_s2;
   assign pd_brk_rd = re ? rxd_s2 : brk_port_reg;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         txd_out <= 1'b1;
         sck_out <= 1'b0;
         sck_oe_out <= 1'b0;
      end else begin
         txd_out <= brk_drive ? brk_port_reg : tx_serial_reg;
         // Port override only when the serial clock functions are off
         sck_oe_out <= clk_drive | (portctl_reg[PC_CLK_OUT] & ~ext_clk);
         sck_out <= clk_drive ? clk_level : clk_port_reg;
      end
   end

   // Read multiplexer; unmapped reads return zero with slave error
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (req.addr)
         OFF_FORMAT: rd_mux[7:0] = format_reg;
         OFF_RATE: rd_mux[7:0] = rate_reg;
         OFF_CONTROL: rd_mux[7:0] = control_reg;
         OFF_TXDATA: rd_mux[7:0] = txhold_reg;
         OFF_STATUS: rd_mux[7:0] = status_reg;
         OFF_RXDATA: rd_mux[7:0] = rx_holding_reg;
         OFF_PORTCTL: rd_mux[15:0] = portctl_reg;
         OFF_PORTDAT: rd_mux[1:0] = {pd_clk_rd, pd_brk_rd};
         default: rd_mux = 32'h0000_0000;
      endcase
   end
   // Read word captured in the setup cycle: the bus sees a flop, still no wait state,
   // and the flags remembered for clearing are exactly the ones software was shown
   logic rd_setup;
   assign rd_setup = req.sel & ~req.enable & ~req.write;
   always_ff @(posedge clk_in) begin
      if (rst_in) rd_data_reg <= 32'h0000_0000;
      else rd_data_reg <= rd_setup ? rd_mux : 32'h0000_0000;
   end
   assign prdata_out = rd_data_reg;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence s_read_one;
      rd_status && rd_data_reg[ST_RX_HOLDING_FULL];
   endsequence

   a_reset_value: assert property (standby_in |=> status_reg == STATUS_RESET)
      else $error("status not 0x84 after reset");
   a_no_sw_set: assert property (!hw_set[ST_OVR] && !status_reg[ST_OVR] |=> !status_reg[ST_OVR])
      else $error("overrun set without cause");
   a_clear_needs_read: assert property (status_reg[ST_RX_HOLDING_FULL] && wr_status && !seen_reg[ST_RX_HOLDING_FULL]
      |=> status_reg[ST_RX_HOLDING_FULL])
      else $error("receive-full cleared without prior read");
   a_read_then_clear: assert property (s_read_one ##1 (!wr_status) [*2] ##1 (wr_status
      && !req.wdata[ST_RX_HOLDING_FULL] && !hw_set[ST_RX_HOLDING_FULL]) |=> !status_reg[ST_RX_HOLDING_FULL])
      else $error("read-one write-zero did not clear");
   a_tx_finished_readonly: assert property (wr_status && !hw_set[ST_TX_FINISHED] && !sw_clr[ST_TX_HOLDING_EMPTY]
      && !tx_load |=> status_reg[ST_TX_FINISHED] == $past(status_reg[ST_TX_FINISHED]))
      else $error("transmit-end changed by write");
   a_te_off_flags: assert property (!te && !clr_all |=> status_reg[ST_TX_HOLDING_EMPTY] && status_reg[ST_TX_FINISHED])
      else $error("flags not set with transmitter off");
   a_overrun_keep: assert property (rx_done && status_reg[ST_RX_HOLDING_FULL]
      |=> status_reg[ST_OVR] && $stable(rx_holding_reg))
      else $error("overrun not flagged or data overwritten");
   a_error_no_full: assert property (rx_done && !status_reg[ST_RX_HOLDING_FULL] && (rx_frm || rx_par)
      |=> !status_reg[ST_RX_HOLDING_FULL] && rx_holding_reg == $past(rx_char))
      else $error("error frame set receive-full");
   a_set_wins: assert property (hw_set[ST_RX_HOLDING_FULL] |=> status_reg[ST_RX_HOLDING_FULL])
      else $error("set lost to clear");
   a_break_pin: assert property (brk_drive |=> txd_out == $past(brk_port_reg))
      else $error("break value not on transmit pin");
endmodule : serial_status_and_port_control
`default_nettype wire

// ===== pkg/serial_pkg.sv
// Package with register map, field positions, reset values and timing for the serial block
package serial_pkg;
   // ****************************************
   // Register byte offsets on the APB bus
   // ****************************************
   localparam logic [7:0] OFF_FORMAT = 8'h00;
   localparam logic [7:0] OFF_RATE = 8'h04;
   localparam logic [7:0] OFF_CONTROL = 8'h08;
   localparam logic [7:0] OFF_TXDATA = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_RXDATA = 8'h14;
   localparam logic [7:0] OFF_PORTCTL = 8'h18;
   localparam logic [7:0] OFF_PORTDAT = 8'h1c;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] STATUS_RESET = 8'h84;
   localparam logic [15:0] PORTCTL_RESET = 16'ha888;
   localparam logic [7:0] RATE_RESET = 8'hff;

   // ****************************************
   // Status bit positions
   // ****************************************
   localparam int ST_TX_HOLDING_EMPTY = 7;
   localparam int ST_RX_HOLDING_FULL = 6;
   localparam int ST_OVR = 5;
   localparam int ST_FRM = 4;
   localparam int ST_PAR = 3;
   localparam int ST_TX_FINISHED = 2;
   localparam int ST_MPB = 1;
   localparam int ST_TX_MULTIPROC_BIT = 0;

   // ****************************************
   // Control, format and port bit positions
   // ****************************************
   localparam int CT_TE = 5;
   localparam int CT_RE = 4;
   localparam int CT_CLOCK_SOURCE_EXTERNAL = 1;
   localparam int CT_CLOCK_PIN_OUTPUT = 0;
   localparam int FM_SYNC = 7;
   localparam int FM_CHR7 = 6;
   localparam int FM_PE = 5;
   localparam int FM_ODD = 4;
   localparam int FM_STOP2 = 3;
   localparam int FM_MP = 2;
   localparam int PC_CLK_OUT = 2;
   localparam int PC_BRK_OUT = 0;
   localparam int PD_CLK = 1;
   localparam int PD_BRK = 0;

   // ****************************************
   // Timing: external async clock is 16x bit rate
   // ****************************************
   localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
   localparam logic [3:0] OVERSAMPLE_MID = 4'h7;

   // Bus request carrier
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [7:0] addr;
      logic [31:0] wdata;
   } apb_req_t;

   typedef enum logic [3:0] {
      TX_IDLE = 4'b0001,
      TX_START = 4'b0010,
      TX_BITS = 4'b0100,
      TX_STOP = 4'b1000
   } tx_state_t;

   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001,
      RX_START = 4'b0010,
      RX_BITS = 4'b0100,
      RX_STOP = 4'b1000
   } rx_state_t;
endpackage : serial_pkg

// ===== verif/serial_partner.sv
// Behavioural remote serial device on the receive, transmit and clock pins
`timescale 1ns/1ps
`default_nettype none
module serial_partner (
   input wire logic txd_in,
   output logic rxd_out,
   output logic sck_out
);
   logic run_clk = 1'b0;
   logic idle_lvl = 1'b0;

   // Link clock at sixteen times the bit rate, parked between frames
   initial begin
      rxd_out = 1'b1;
      sck_out = 1'b0;
      #7;
      forever #160 sck_out = run_clk ? ~sck_out : idle_lvl;
   end

   // Send a frame LSB first, bit 0 being the start bit; 16 clocks per bit
   task automatic send(input logic [10:0] bits, input int n);
      run_clk = 1'b1;
      repeat (4) @(negedge sck_out);
      for (int i = 0; i < n; i++) begin
         rxd_out = bits[i];
         repeat (16) @(negedge sck_out);
      end
      rxd_out = 1'b1;
      repeat (24) @(negedge sck_out);
      run_clk = 1'b0;
   endtask : send

   // Capture a frame at mid-bit; a missing start bit leaves all ones
   task automatic grab(output logic [10:0] bits, input int n);
      int k;
      bits = '1;
      run_clk = 1'b1;
      k = 0;
      while (txd_in !== 1'b0 && k < 400) begin
         @(negedge sck_out);
         k++;
      end
      if (k < 400) begin
         repeat (8) @(negedge sck_out);
         for (int i = 0; i < n; i++) begin
            bits[i] = txd_in;
            repeat (16) @(negedge sck_out);
         end
         repeat (16) @(negedge sck_out);
      end
      run_clk = 1'b0;
   endtask : grab
endmodule : serial_partner
`default_nettype wire

// ===== verif/test_serial_status_and_port_control.sv
// Self-checking bench for the serial status and port control block
`timescale 1ns/1ps
`default_nettype none
module test_serial_status_and_port_control;
   import serial_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic standby_in = 1'b0;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0;
   logic [31:0] prdata_out;
   logic [31:0] q;
   logic [10:0] fr;
   logic pready_out, pslverr_out, txd_out, rxd_wire, sck_dut, sck_oe_out, sck_far, slv_err;
   wire logic sck_wire;
   int err_count = 0;
   int compares = 0;

   // Clock pin level: the block wins while it drives, else the far side
   assign sck_wire = sck_oe_out ? sck_dut : sck_far;
   always #20 clk_in = ~clk_in;

   serial_status_and_port_control i_dut (.clk_in(clk_in), .rst_in(rst_in),
      .standby_in(standby_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .txd_out(txd_out), .rxd_in(rxd_wire), .sck_in(sck_wire), .sck_out(sck_dut),
      .sck_oe_out(sck_oe_out));
   serial_partner i_partner (.txd_in(txd_out), .rxd_out(rxd_wire), .sck_out(sck_far));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic end_sim;
      if (err_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One APB transfer; read data and error taken at the pready edge only
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 20);
      q = prdata_out;
      slv_err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      if (n >= 20) begin
         err_count++;
         $display("mismatch apb_wait expected 1 seen %b", pready_out);
         end_sim();
      end
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(what, exp, q);
   endtask : rdchk

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic transmit_frame;
      rdchk(OFF_STATUS, 32'h84, "status_reset");
      rdchk(OFF_PORTCTL, 32'ha888, "port_ctl_reset");
      apb(1'b0, 8'h20, 32'h0);
      chk("slverr", 32'h1, {31'h0, slv_err});
      wr(OFF_FORMAT, 32'h04);
      wr(OFF_CONTROL, 32'h22);
      wr(OFF_STATUS, 32'hff);
      rdchk(OFF_STATUS, 32'h85, "status_no_set");
      wr(OFF_TXDATA, 32'ha5);
      rdchk(OFF_STATUS, 32'h05, "status_loaded");
      i_partner.grab(fr, 11);
      chk("tx_frame", 32'h74a, {21'h0, fr});
      rdchk(OFF_STATUS, 32'h85, "status_tx_done");
      wr(OFF_STATUS, 32'h7f);
      rdchk(OFF_STATUS, 32'h01, "status_tx_holding_empty_clr");
      wr(OFF_CONTROL, 32'h02);
      rdchk(OFF_STATUS, 32'h85, "status_tx_off");
   endtask : transmit_frame

   // Receive, overrun, framing, parity (even and odd) and multiprocessor bit
   task automatic receive_flags;
      wr(OFF_FORMAT, 32'h00);
      wr(OFF_CONTROL, 32'h12);
      i_partner.send(11'h278, 10);
      rdchk(OFF_STATUS, 32'hc5, "status_rx_full");
      rdchk(OFF_RXDATA, 32'h3c, "rx_data");
      i_partner.send(11'h2aa, 10);
      rdchk(OFF_STATUS, 32'he5, "status_overrun");
      rdchk(OFF_RXDATA, 32'h3c, "rx_kept");
      wr(OFF_STATUS, 32'h9f);
      rdchk(OFF_STATUS, 32'h85, "status_cleared");
      i_partner.send(11'h102, 10);
      rdchk(OFF_STATUS, 32'h95, "status_framing");
      rdchk(OFF_RXDATA, 32'h81, "rx_copied");
      wr(OFF_CONTROL, 32'h02);
      rdchk(OFF_STATUS, 32'h95, "status_re_off");
      wr(OFF_STATUS, 32'hef);
      wr(OFF_FORMAT, 32'h20);
      wr(OFF_CONTROL, 32'h12);
      i_partner.send(11'h606, 11);
      rdchk(OFF_STATUS, 32'h8d, "status_parity_even");
      i_partner.send(11'h406, 11);
      rdchk(OFF_STATUS, 32'h8d, "status_rx_halted");
      wr(OFF_STATUS, 32'hf7);
      wr(OFF_FORMAT, 32'h30);
      i_partner.send(11'h406, 11);
      rdchk(OFF_STATUS, 32'h8d, "status_parity_odd");
      wr(OFF_STATUS, 32'hf7);
      wr(OFF_FORMAT, 32'h04);
      i_partner.send(11'h622, 11);
      rdchk(OFF_STATUS, 32'hc7, "status_mp_bit");
      wr(OFF_STATUS, 32'hbf);
      wr(OFF_CONTROL, 32'h02);
      rdchk(OFF_STATUS, 32'h87, "status_mp_kept");
   endtask : receive_flags

   // Port override of both pins, then pin readback
   task automatic port_pins;
      wr(OFF_CONTROL, 32'h00);
      wr(OFF_PORTCTL, 32'h05);
      wr(OFF_PORTDAT, 32'h02);
      repeat (3) @(posedge clk_in);
      chk("sck_pin", 32'h3, {30'h0, sck_oe_out, sck_dut});
      chk("txd_pin", 32'h0, {31'h0, txd_out});
      wr(OFF_PORTCTL, 32'h00);
      i_partner.idle_lvl = 1'b1;
      wr(OFF_PORTDAT, 32'h00);
      wr(OFF_CONTROL, 32'h10);
      chk("sck_released", 32'h0, {31'h0, sck_oe_out});
      rdchk(OFF_PORTDAT, 32'h03, "port_readback");
      i_partner.idle_lvl = 1'b0;
   endtask : port_pins

   // Internal clock output at bit rate, then standby returns status
   task automatic clock_and_standby;
      int rises;
      logic prev;
      rises = 0;
      wr(OFF_RATE, 32'h00);
      wr(OFF_CONTROL, 32'h01);
      repeat (4) @(posedge clk_in);
      prev = sck_dut;
      repeat (160) begin
         @(posedge clk_in);
         if (sck_dut === 1'b1 && prev === 1'b0) rises++;
         prev = sck_dut;
      end
      chk("sck_clk_oe", 32'h1, {31'h0, sck_oe_out});
      chk("sck_rate_ok", 32'h1, {31'h0, rises >= 9 && rises <= 11});
      standby_in <= 1'b1;
      @(posedge clk_in);
      standby_in <= 1'b0;
      rdchk(OFF_STATUS, 32'h84, "status_standby");
   endtask : clock_and_standby

   // Main sequence after a 16-cycle reset
   initial begin
      repeat (16) @(posedge clk_in);
      rst_in <= 1'b0;
      transmit_frame();
      receive_flags();
      port_pins();
      clock_and_standby();
      end_sim();
   end
endmodule : test_serial_status_and_port_control
`default_nettype wire
